// ==== test_uart_auto_baud_detect.sv ====
// self-checking bench for the auto-baud core
`include "uabd_consts.svh"
`default_nettype none
module test_uart_auto_baud_detect;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    wire logic rx_line;
    logic o_rx_hold_idle;
    logic o_rx_flag;
    logic [15:0] o_divisor;
    logic [7:0] rd_val;
    logic rx_byte_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    int n_errors = 0;
    int checks_done = 0;
    always #5 i_core_clk = ~i_core_clk;
    uabd_core u_dut (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_rx(rx_line),
        .i_rx_byte_valid(rx_byte_valid),
        .i_rx_byte(rx_byte),
        .o_rx_hold_idle(o_rx_hold_idle),
        .o_rx_flag(o_rx_flag),
        .o_divisor(o_divisor)
    );
    uabd_tx_model u_tx (
        .i_core_clk(i_core_clk),
        .o_rx(rx_line)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg,
                     seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask : rd
    // one-cycle byte pulse from the receiver, outputs settled on return
    task automatic pulse_byte(input logic [7:0] b);
        @(posedge i_core_clk);
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        @(posedge i_core_clk);
        rx_byte_valid <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : pulse_byte
    task automatic test_reset;
        check(o_rx_hold_idle, 1'b0, "hold idle reset");
        check(o_rx_flag, 1'b0, "flag reset");
        check(o_divisor, `UABD_DIV_RST, "divisor reset");
        rd(`UABD_OFF_STATUS);
        check(rd_val, 8'h02, "status reset");
        rd(`UABD_OFF_CTRL);
        check(rd_val, `UABD_CTRL_RST, "ctrl reset");
        rd(`UABD_OFF_DIV_LO);
        check(rd_val, 8'h00, "div lo reset");
        rd(4'hf);
        check(rd_val, 8'h00, "unmapped read");
        $display("test reset done");
    endtask : test_reset
    task automatic test_rx_path;
        wr(`UABD_OFF_CTRL, 8'h01);
        pulse_byte(8'ha5);
        check(o_rx_flag, 1'b0, "byte ignored while busy");
        wr(`UABD_OFF_CTRL, 8'h00);
        pulse_byte(8'h3c);
        check(o_rx_flag, 1'b1, "byte after release");
        rd(`UABD_OFF_RXDATA);
        check(rd_val, 8'h3c, "byte data");
        $display("test rx path done");
    endtask : test_rx_path
    // tick phase is free running, so the count may be off by one
    task automatic calib(input logic [1:0] mode, input logic wake,
                         input int bitlen);
        int per;
        logic [15:0] exp;
        logic ok;
        per = (mode == 2'b00) ? 512 : (mode == 2'b11) ? 32 : 128;
        exp = 16'(1 + 8 * bitlen / per);
        wr(`UABD_OFF_CTRL, {3'b000, wake, mode[0], mode[1], 2'b01});
        repeat (3) @(posedge i_core_clk);
        check(o_rx_hold_idle, 1'b1, "hold idle");
        if (wake) begin
            u_tx.send_break(10 * bitlen);
            check(o_rx_hold_idle, 1'b1, "still calibrating");
        end
        u_tx.send_byte(8'h55, bitlen);
        @(posedge i_core_clk);
        #1 check(o_rx_flag, 1'b1, "flag set");
        check(o_rx_hold_idle, 1'b0, "hold released");
        ok = (o_divisor + 16'h0001 >= exp) && (o_divisor <= exp + 16'h0001);
        check(ok, 1'b1, "divisor");
        rd(`UABD_OFF_CTRL);
        check(rd_val[`UABD_BIT_START], 1'b0, "start cleared");
        rd(`UABD_OFF_DIV_HI);
        check(rd_val, exp[15:8], "high byte");
        rd(`UABD_OFF_RXDATA);
        rd(`UABD_OFF_STATUS);
        check(rd_val[`UABD_BIT_RXFLAG], 1'b0, "flag cleared");
        check(o_rx_flag, 1'b0, "flag out cleared");
        $display("test calib mode %b wake %b done", mode, wake);
    endtask : calib
    task automatic test_abort;
        wr(`UABD_OFF_CTRL, 8'h0d);
        u_tx.send_break(64);
        wr(`UABD_OFF_CTRL, 8'h02);
        repeat (2) @(posedge i_core_clk);
        check(o_rx_hold_idle, 1'b0, "abort release");
        check(o_rx_flag, 1'b0, "no flag on abort");
        rd(`UABD_OFF_CTRL);
        check(rd_val[1:0], 2'b00, "abort ctrl");
        $display("test abort done");
    endtask : test_abort
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        #1_000_000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        test_reset();
        test_rx_path();
        calib(2'b00, 1'b0, 512);
        calib(2'b10, 1'b0, 512);
        calib(2'b11, 1'b0, 512);
        calib(2'b01, 1'b0, 4096);
        test_abort();
        calib(2'b11, 1'b1, 512);
        end_sim();
    end
endmodule : test_uart_auto_baud_detect
`default_nettype wire

// ==== uabd_consts.svh ====
// register offsets, field positions and counts for the auto-baud block
`ifndef UABD_CONSTS_SVH
`define UABD_CONSTS_SVH
`define UABD_OFF_CTRL 4'h0
`define UABD_OFF_DIV_LO 4'h1
`define UABD_OFF_DIV_HI 4'h2
`define UABD_OFF_RXDATA 4'h3
`define UABD_OFF_STATUS 4'h4
`define UABD_BIT_START 0
`define UABD_BIT_OVF 1
`define UABD_BIT_WIDE 2
`define UABD_BIT_HSPD 3
`define UABD_BIT_WAKE 4
`define UABD_BIT_RXFLAG 0
`define UABD_BIT_IDLE 1
`define UABD_BIT_BUSY 2
`define UABD_CTRL_RST 8'h00
`define UABD_DIV_RST 16'h0000
`define UABD_CNT_START 16'h0001
`define UABD_RISE_LAST 3'h5
`define UABD_TICK_DIV_00 10'h200
`define UABD_TICK_DIV_01 10'h080
`define UABD_TICK_DIV_11 10'h020
`endif

// ==== uabd_core.sv ====
// auto-baud detection core with register port
`include "uabd_consts.svh"
`default_nettype none
module uabd_core (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_rx,
    input wire logic i_rx_byte_valid,
    input wire logic [7:0] i_rx_byte,
    output logic o_rx_hold_idle,
    output logic o_rx_flag,
    output logic [15:0] o_divisor
);
    uabd_pkg::uabd_state_e state_q;
    logic start_q;
    logic ovf_q;
    logic wide_q;
    logic hspd_q;
    logic wake_q;
    logic rxflag_q;
    logic brk_seen_q;
    logic [15:0] div_q;
    logic [7:0] rxdata_q;
    logic [2:0] rise_q;
    logic tick;
    logic rise;
    logic fall;
    logic line;
    logic done;
    logic ovf_evt;
    logic wr_ctrl;
    logic rd_rxdata;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction : hit

    assign wr_ctrl = i_wr & hit(i_addr, `UABD_OFF_CTRL);
    assign rd_rxdata = i_rd & hit(i_addr, `UABD_OFF_RXDATA);

    uabd_tick_gen u_tick (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_wide(wide_q),
        .i_hspd(hspd_q),
        .o_tick(tick)
    );

    uabd_edge_det u_edge (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_rx(i_rx),
        .o_rise(rise),
        .o_fall(fall),
        .o_level(line)
    );

    assign done = (state_q == uabd_pkg::UABD_COUNT) & rise
        & (rise_q == `UABD_RISE_LAST - 3'h1);
    assign ovf_evt = (state_q == uabd_pkg::UABD_COUNT) & tick
        & (div_q == 16'hffff) & ~done;

    // calibration sequencer
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q <= uabd_pkg::UABD_IDLE;
            rise_q <= 3'h0;
            brk_seen_q <= 1'b0;
        end else if (!start_q) begin
            state_q <= uabd_pkg::UABD_IDLE;
            rise_q <= 3'h0;
            brk_seen_q <= 1'b0;
        end else begin
            case (state_q)
                uabd_pkg::UABD_IDLE: begin
                    // break must finish first when wake is armed
                    if (!wake_q || brk_seen_q) begin
                        state_q <= uabd_pkg::UABD_WAIT_START;
                    end else if (fall) begin
                        brk_seen_q <= 1'b0;
                    end else if (rise) begin
                        brk_seen_q <= 1'b1;
                    end
                end
                uabd_pkg::UABD_WAIT_START: begin
                    if (fall) begin
                        state_q <= uabd_pkg::UABD_WAIT_RISE;
                    end
                end
                uabd_pkg::UABD_WAIT_RISE: begin
                    if (rise) begin
                        state_q <= uabd_pkg::UABD_COUNT;
                        rise_q <= 3'h1;
                    end
                end
                uabd_pkg::UABD_COUNT: begin
                    if (rise) begin
                        rise_q <= rise_q + 3'h1;
                    end
                    if (done) begin
                        state_q <= uabd_pkg::UABD_IDLE;
                        rise_q <= 3'h0;
                    end
                end
                default: state_q <= uabd_pkg::UABD_IDLE;
            endcase
        end
    end

    // start bit: software sets, hardware clears on completion
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            start_q <= 1'b0;
            wide_q <= 1'b0;
            hspd_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                start_q <= i_wdata[`UABD_BIT_START];
                wide_q <= i_wdata[`UABD_BIT_WIDE];
                hspd_q <= i_wdata[`UABD_BIT_HSPD];
                wake_q <= i_wdata[`UABD_BIT_WAKE];
            end
            if (done) begin
                start_q <= 1'b0;
            end
            // wake bit drops at the end of the break
            if (wake_q && start_q && state_q == uabd_pkg::UABD_IDLE
                    && rise) begin
                wake_q <= 1'b0;
            end
        end
    end

    // overflow flag: set wins; clear only while start is low
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            ovf_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_q <= 1'b1;
        end else if (wr_ctrl && !start_q && !i_wdata[`UABD_BIT_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    // divisor pair doubles as the 16-bit measuring counter
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            div_q <= `UABD_DIV_RST;
        end else if (state_q == uabd_pkg::UABD_WAIT_RISE && rise) begin
            div_q <= `UABD_CNT_START;
        end else if (state_q == uabd_pkg::UABD_COUNT) begin
            if (tick && !done) begin
                div_q <= div_q + 16'h0001;
            end
        end else if (i_wr && hit(i_addr, `UABD_OFF_DIV_LO)) begin
            div_q[7:0] <= i_wdata;
        end else if (i_wr && hit(i_addr, `UABD_OFF_DIV_HI)) begin
            div_q[15:8] <= i_wdata;
        end
    end

    // receive flag and data; set wins over the clearing read
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            rxflag_q <= 1'b0;
            rxdata_q <= 8'h00;
        end else if (done) begin
            rxflag_q <= 1'b1;
        end else if (i_rx_byte_valid && !start_q) begin
            rxflag_q <= 1'b1;
            rxdata_q <= i_rx_byte;
        end else if (rd_rxdata) begin
            rxflag_q <= 1'b0;
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `UABD_OFF_CTRL: o_rdata <= {3'h0, wake_q, hspd_q, wide_q,
                    ovf_q, start_q};
                `UABD_OFF_DIV_LO: o_rdata <= div_q[7:0];
                `UABD_OFF_DIV_HI: o_rdata <= div_q[15:8];
                `UABD_OFF_RXDATA: o_rdata <= rxdata_q;
                `UABD_OFF_STATUS: o_rdata <= {5'h00,
                    state_q == uabd_pkg::UABD_COUNT,
                    line & ~start_q, rxflag_q};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // outputs registered; receiver released as soon as start drops
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rx_hold_idle <= 1'b0;
            o_rx_flag <= 1'b0;
            o_divisor <= `UABD_DIV_RST;
        end else begin
            o_rx_hold_idle <= start_q & ~done;
            o_rx_flag <= rxflag_q;
            o_divisor <= div_q;
        end
    end

    chk_done_clears_start: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b) done |=> !start_q && rxflag_q)
        else $error("start bit not cleared at completion");

    chk_count_starts_one: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (state_q == uabd_pkg::UABD_WAIT_RISE && rise && start_q)
        |=> div_q == 16'h0001)
        else $error("counter did not start at one");

    chk_ovf_sets_flag: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b) ovf_evt |=> ovf_q && div_q == 16'h0000)
        else $error("overflow not flagged");

    chk_ovf_holds: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b) (ovf_q && start_q) |=> ovf_q)
        else $error("overflow cleared while start set");

    chk_read_clears: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (rd_rxdata && !done && !i_rx_byte_valid) |=> !rxflag_q)
        else $error("receive flag not cleared by read");

    chk_hold_idle: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b) (start_q && !done) |=> o_rx_hold_idle)
        else $error("receiver not held idle");

    chk_count_tick: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (state_q == uabd_pkg::UABD_COUNT && !tick && start_q)
        |=> $stable(div_q))
        else $error("counter moved without a tick");

    chk_release_idle: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b) done |=> ##1 !o_rx_hold_idle)
        else $error("receiver not released");

    chk_rise_bounded: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (state_q == uabd_pkg::UABD_COUNT) |-> rise_q >= 3'h1
        && rise_q <= `UABD_RISE_LAST - 3'h1)
        else $error("rise count out of range");

    chk_first_rise: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (state_q == uabd_pkg::UABD_WAIT_RISE && rise && start_q)
        |=> state_q == uabd_pkg::UABD_COUNT)
        else $error("count did not start on first rise");

    chk_count_step: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (state_q == uabd_pkg::UABD_COUNT && tick && !done && start_q)
        |=> div_q == $past(div_q) + 16'h0001)
        else $error("counter did not step on a tick");

    chk_rx_ignored: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_rx_byte_valid && start_q && !done && !rxflag_q)
        |=> !rxflag_q)
        else $error("byte taken while calibrating");

    chk_wake_clear: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (wake_q && start_q && state_q == uabd_pkg::UABD_IDLE && rise)
        |=> !wake_q)
        else $error("wake bit not cleared after break");
endmodule : uabd_core
`default_nettype wire

// ==== uabd_edge_det.sv ====
// rising and falling edge finder on the receive line
`default_nettype none
module uabd_edge_det (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_rx,
    output logic o_rise,
    output logic o_fall,
    output logic o_level
);
    logic prev_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= i_rx;
        end
    end

    assign o_rise = i_rx & ~prev_q;
    assign o_fall = ~i_rx & prev_q;
    assign o_level = prev_q;
endmodule : uabd_edge_det
`default_nettype wire

// ==== uabd_pkg.sv ====
// types for the auto-baud block
`default_nettype none
package uabd_pkg;
    typedef enum logic [3:0] {
        UABD_IDLE = 4'b0001,
        UABD_WAIT_START = 4'b0010,
        UABD_WAIT_RISE = 4'b0100,
        UABD_COUNT = 4'b1000
    } uabd_state_e;
endpackage : uabd_pkg
`default_nettype wire

// ==== uabd_tick_gen.sv ====
// auto-baud counter clock enable from the system clock
`include "uabd_consts.svh"
`default_nettype none
module uabd_tick_gen (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_wide,
    input wire logic i_hspd,
    output logic o_tick
);
    logic [9:0] div_q;
    logic [9:0] lim;

    always_comb begin
        case ({i_wide, i_hspd})
            2'b00: lim = `UABD_TICK_DIV_00;
            2'b11: lim = `UABD_TICK_DIV_11;
            default: lim = `UABD_TICK_DIV_01;
        endcase
    end

    // prescaler runs freely; first tick phase is not aligned to the edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            div_q <= 10'h000;
            o_tick <= 1'b0;
        end else if (div_q >= lim - 10'h001) begin
            div_q <= 10'h000;
            o_tick <= 1'b1;
        end else begin
            div_q <= div_q + 10'h001;
            o_tick <= 1'b0;
        end
    end
endmodule : uabd_tick_gen
`default_nettype wire

// ==== uabd_tx_model.sv ====
// remote serial transmitter model driving the receive line
`default_nettype none
module uabd_tx_model (
    input wire logic i_core_clk,
    output logic o_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_rx = 1'b1;
    task automatic put(input logic b, input int len);
        o_rx <= b;
        repeat (len) @(posedge i_core_clk);
    endtask : put
    // lsb first; the stop bit gives the fifth rise of a 55h
    task automatic send_byte(input logic [7:0] d, input int len);
        put(1'b0, len);
        for (int i = 0; i < 8; i++) begin
            put(d[i], len);
        end
        put(1'b1, len);
    endtask : send_byte
    // long low, then back to idle high
    task automatic send_break(input int len);
        put(1'b0, len);
        put(1'b1, len);
    endtask : send_break
endmodule : uabd_tx_model
`default_nettype wire
